//--- src/audio_dsp_path_config.v
/*
  signal path configuration register bank: four byte-wide registers on
  the device control port, decoded into steering outputs for the filter
  path. assumes a byte-address write/read port synchronous to ref_clk.
  reserved bits 7:6 of the filter path register read back as zero.
  the host is expected to keep reserved mode and ceiling codes out;
  should one arrive anyway, the decoded outputs hold or clamp so the
  filter path never sees an undefined selection.
  decoded outputs follow the registers one clock later.
*/
`timescale 1ns/10ps
`include "audio_dsp_path_config_defs.vh"

module audio_dsp_path_config
#(
  parameter NUM_CH = 8
)
(
  // clock and reset
  input  wire              ref_clk,
  input  wire              rst,
  // register port
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  output reg               reg_rvalid,
  // per-channel volume codes, channel one in the low byte
  input  wire [8*NUM_CH-1:0] channel_volume_code,
  // decoded path controls
  output reg  [1:0]        decimation_response_select,
  output reg  [1:0]        channel_summing_mode,
  output reg  [1:0]        highpass_select,
  output reg               highpass_programmable,
  output reg  [2:0]        sum_output_count,
  output reg  [1:0]        biquad_count,
  output reg               soft_step_enable,
  output reg  [NUM_CH-1:0] automatic_gain_loop_active,
  output reg  [3:0]        gain_loop_target_level,
  output reg  [3:0]        gain_loop_ceiling,
  output reg  [NUM_CH-1:0] input_channel_enable,
  output reg  [8*NUM_CH-1:0] digital_volume,
  output reg  [NUM_CH-1:0] channel_muted
);

  // register storage
  reg  [7:0] fpc_q;
  reg  [7:0] vbc_q;
  reg  [7:0] glc_q;
  reg  [7:0] ice_q;
  reg  [7:0] rdata_d;
  reg  [8*NUM_CH-1:0] vol_d;
  // separate loop indices so each process owns its own variable
  integer i;
  integer j;

  // true for the one reserved code of a two-bit mode field
  function is_reserved_code;
    input [1:0] code;
    begin
      is_reserved_code = (code == 2'h3);
    end
  endfunction

  // enable bit of channel n+1; channel one sits at bit 7
  function channel_on;
    input [7:0]   enables;
    input integer n;
    begin
      channel_on = enables[7-n];
    end
  endfunction

  // reserved ceiling codes fall back to the highest legal code
  function [3:0] clamp_ceiling;
    input [3:0] code;
    begin
      if (code > `CEIL_MAX_CODE)
        clamp_ceiling = `CEIL_MAX_CODE;
      else
        clamp_ceiling = code;
    end
  endfunction

  // read mux, unmapped addresses read zero
  always @*
  begin
    case (reg_addr)
      `ADDR_FILTER_PATH_CONFIG:   rdata_d = fpc_q;
      `ADDR_VOLUME_BIQUAD_CONFIG: rdata_d = vbc_q;
      `ADDR_GAIN_LOOP_CONFIG:     rdata_d = glc_q;
      `ADDR_INPUT_CHANNEL_ENABLE: rdata_d = ice_q;
      default:                    rdata_d = 8'h00;
    endcase
  end

  // register writes; reserved bits 7:6 of filter path stay zero
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      fpc_q <= `RST_FILTER_PATH_CONFIG;
      vbc_q <= `RST_VOLUME_BIQUAD_CONFIG;
      glc_q <= `RST_GAIN_LOOP_CONFIG;
      ice_q <= `RST_INPUT_CHANNEL_ENABLE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_FILTER_PATH_CONFIG:   fpc_q <= reg_wdata & `FPC_WMASK;
        `ADDR_VOLUME_BIQUAD_CONFIG: vbc_q <= reg_wdata;
        `ADDR_GAIN_LOOP_CONFIG:     glc_q <= reg_wdata;
        `ADDR_INPUT_CHANNEL_ENABLE: ice_q <= reg_wdata;
        // unmapped addresses leave every register as it was
        default:                    fpc_q <= fpc_q;
      endcase
    end
  end

  // read answer, one cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      // zero outside a read so a stale value never leaks
      reg_rdata  <= reg_rd ? rdata_d : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // volume source per channel, gang takes channel one's code
  always @*
  begin
    vol_d = {8*NUM_CH{1'b0}};
    for (i = 0; i < NUM_CH; i = i + 1)
    begin
      // a disabled channel is muted whatever its code
      if (!channel_on(ice_q, i))
        vol_d[8*i +: 8] = `VOL_MUTE_CODE;
      else if (vbc_q[`GANG_BIT])
        vol_d[8*i +: 8] = channel_volume_code[7:0];
      else
        vol_d[8*i +: 8] = channel_volume_code[8*i +: 8];
    end
  end

  // registered decode of all controls
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      // decoded copies of the register reset values; channel enables and volumes reset to zero, all muted
      decimation_response_select <= `DECI_LINEAR;
      channel_summing_mode       <= `SUM_NONE;
      highpass_select            <= 2'h1;
      highpass_programmable      <= 1'b0;
      sum_output_count           <= 3'h4;
      biquad_count               <= 2'h2;
      soft_step_enable           <= 1'b1;
      automatic_gain_loop_active <= {NUM_CH{1'b0}};
      gain_loop_target_level     <= 4'he;
      gain_loop_ceiling          <= 4'h7;
      input_channel_enable       <= {NUM_CH{1'b0}};
      digital_volume             <= {8*NUM_CH{1'b0}};
      channel_muted              <= {NUM_CH{1'b1}};
    end
    else
    begin
      // filter path fields; reserved code 3 holds the previous response
      if (!is_reserved_code(fpc_q[`DECI_MSB:`DECI_LSB]))
        decimation_response_select <= fpc_q[`DECI_MSB:`DECI_LSB];
      if (!is_reserved_code(fpc_q[`SUM_MSB:`SUM_LSB]))
        channel_summing_mode <= fpc_q[`SUM_MSB:`SUM_LSB];
      case (fpc_q[`SUM_MSB:`SUM_LSB])
        `SUM_PAIRS: sum_output_count <= 3'h2;
        `SUM_QUAD:  sum_output_count <= 3'h1;
        `SUM_NONE:  sum_output_count <= 3'h4;
        default:    sum_output_count <= sum_output_count;
      endcase
      highpass_select       <= fpc_q[`HPF_MSB:`HPF_LSB];
      highpass_programmable <= (fpc_q[`HPF_MSB:`HPF_LSB] == `HPF_PROGRAMMABLE);
      // volume and biquad fields
      biquad_count          <= vbc_q[`BIQ_MSB:`BIQ_LSB];
      soft_step_enable      <= ~vbc_q[`SOFT_DIS_BIT];
      // per-channel enables, gain loop and mute flags
      for (j = 0; j < NUM_CH; j = j + 1)
      begin
        input_channel_enable[j]       <= channel_on(ice_q, j);
        automatic_gain_loop_active[j] <= channel_on(ice_q, j) & vbc_q[`GLSEL_BIT];
        channel_muted[j]              <= (vol_d[8*j +: 8] == `VOL_MUTE_CODE);
      end
      digital_volume         <= vol_d;
      // gain loop fields; reserved ceiling codes clamp to the 42 dB code
      gain_loop_target_level <= glc_q[`LVL_MSB:`LVL_LSB];
      gain_loop_ceiling      <= clamp_ceiling(glc_q[`CEIL_MSB:`CEIL_LSB]);
    end
  end

endmodule

//--- src/audio_dsp_path_config_defs.vh
/*
  offsets, field positions and reset values for the signal path
  configuration registers; assumes inclusion by bare name.
*/
`ifndef AUDIO_DSP_PATH_CONFIG_DEFS_VH
`define AUDIO_DSP_PATH_CONFIG_DEFS_VH

// register addresses
`define ADDR_FILTER_PATH_CONFIG   8'h6b
`define ADDR_VOLUME_BIQUAD_CONFIG 8'h6c
`define ADDR_GAIN_LOOP_CONFIG     8'h70
`define ADDR_INPUT_CHANNEL_ENABLE 8'h73

// reset values
`define RST_FILTER_PATH_CONFIG    8'h01
`define RST_VOLUME_BIQUAD_CONFIG  8'h40
`define RST_GAIN_LOOP_CONFIG      8'he7
`define RST_INPUT_CHANNEL_ENABLE  8'hf0

// filter_path_config fields
`define DECI_MSB    5
`define DECI_LSB    4
`define SUM_MSB     3
`define SUM_LSB     2
`define HPF_MSB     1
`define HPF_LSB     0
`define FPC_WMASK   8'h3f

// volume_biquad_config fields
`define GANG_BIT    7
`define BIQ_MSB     6
`define BIQ_LSB     5
`define SOFT_DIS_BIT 4
`define GLSEL_BIT   3

// gain_loop_config fields
`define LVL_MSB     7
`define LVL_LSB     4
`define CEIL_MSB    3
`define CEIL_LSB    0

// codes
`define DECI_LINEAR     2'h0
`define DECI_LOW_LAT    2'h1
`define DECI_ULTRA_LOW  2'h2
`define SUM_NONE        2'h0
`define SUM_PAIRS       2'h1
`define SUM_QUAD        2'h2
`define HPF_PROGRAMMABLE 2'h0
`define CEIL_MAX_CODE   4'hd
`define VOL_MUTE_CODE   8'h00

`endif

//--- verification/audio_dsp_path_config_tb.sv
/* bench for the path config bank: register tasks and checks
   assumes the bank and its checker are compiled first */
`timescale 1ns/10ps
module audio_dsp_path_config_tb;
  logic        ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [63:0] channel_volume_code = 64'h8877665544332211, digital_volume;
  logic [1:0]  decimation_response_select, channel_summing_mode, highpass_select;
  logic [1:0]  biquad_count;
  logic [2:0]  sum_output_count;
  logic [3:0]  gain_loop_target_level, gain_loop_ceiling;
  logic [7:0]  automatic_gain_loop_active, input_channel_enable, channel_muted;
  logic        highpass_programmable, soft_step_enable;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  audio_dsp_path_config dut (.*);
  // clock and hang guard
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      test_done;
    end
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [71:0] got, input logic [71:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge ref_clk);
    reg_wr = 0;
    repeat (2) @(negedge ref_clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge ref_clk);
    reg_rd = 0;
    chk({reg_rvalid, reg_rdata}, {1'b1, e});
  endtask
  // register sequences with expected values
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 0;
    rd(8'h6b, 8'h01);
    rd(8'h6c, 8'h40);
    rd(8'h70, 8'he7);
    rd(8'h73, 8'hf0);
    rd(8'h00, 8'h00);
    chk({highpass_select, biquad_count, gain_loop_target_level}, 8'h6e);
    chk(input_channel_enable, 8'h0f);
    chk({channel_muted, digital_volume}, {8'hf0, 64'h44332211});
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h6b, {2'h0, i[1:0], i[1:0], i[1:0]});
      chk({decimation_response_select, channel_summing_mode}, {i[1:0], i[1:0]});
      chk({highpass_programmable, sum_output_count}, {i == 0, 3'h4 >> i});
    end
    wr(8'h6b, 8'h03);
    chk({highpass_programmable, highpass_select}, 3'h3);
    wr(8'h73, 8'h7f);
    chk(input_channel_enable, 8'hfe);
    rd(8'h73, 8'h7f);
    wr(8'h6c, 8'hc0);
    chk({channel_muted, digital_volume}, {8'h01, 64'h1111111111111100});
    channel_volume_code[7:0] = 8'h00;
    repeat (3) @(negedge ref_clk);
    chk(channel_muted, 8'hff);
    wr(8'h6c, 8'h78);
    chk({biquad_count, soft_step_enable, automatic_gain_loop_active}, 11'h6fe);
    wr(8'h6c, 8'h00);
    chk({biquad_count, soft_step_enable, automatic_gain_loop_active}, 11'h100);
    wr(8'h70, 8'h0d);
    chk({gain_loop_target_level, gain_loop_ceiling}, 8'h0d);
    wr(8'h71, 8'hff);
    rd(8'h70, 8'h0d);
    test_done;
  end
endmodule
bind audio_dsp_path_config path_cfg_sva #(.NUM_CH(NUM_CH)) u_chk (.*);

//--- verification/path_cfg_sva.sv
/* assertions for the path config bank
   sees only the ports of the bank, bound from the bench */
`timescale 1ns/10ps
module path_cfg_sva #(parameter NUM_CH = 8)
(
  // clock, reset, register port
  input logic              ref_clk,
  input logic              rst,
  input logic              reg_wr,
  input logic [7:0]        reg_addr,
  input logic [7:0]        reg_wdata,
  input logic              reg_rvalid,
  // decoded controls
  input logic [1:0]        decimation_response_select,
  input logic [1:0]        channel_summing_mode,
  input logic [1:0]        highpass_select,
  input logic              highpass_programmable,
  input logic [2:0]        sum_output_count,
  input logic              soft_step_enable,
  input logic [3:0]        gain_loop_ceiling,
  input logic [NUM_CH-1:0] input_channel_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // write decode per register
  wire w6b = reg_wr && reg_addr == 8'h6b;
  wire w6c = reg_wr && reg_addr == 8'h6c;
  wire w70 = reg_wr && reg_addr == 8'h70;
  wire w73 = reg_wr && reg_addr == 8'h73;
  property p_deci;
    w6b && reg_wdata[5:4] != 2'h3 |=> ##1 decimation_response_select == $past(reg_wdata[5:4], 2);
  endproperty
  property p_sum0;
    channel_summing_mode == 2'h0 |-> sum_output_count == 3'h4;
  endproperty
  property p_sum1;
    channel_summing_mode == 2'h1 |-> sum_output_count == 3'h2;
  endproperty
  property p_sum2;
    channel_summing_mode == 2'h2 |-> sum_output_count == 3'h1;
  endproperty
  property p_hpf;
    highpass_programmable == (highpass_select == 2'h0);
  endproperty
  property p_soft;
    w6c |=> ##1 soft_step_enable != $past(reg_wdata[4], 2);
  endproperty
  property p_ceil;
    w70 && reg_wdata[3:0] <= 4'hd |=> ##1 gain_loop_ceiling == $past(reg_wdata[3:0], 2);
  endproperty
  property p_inen;
    w73 |=> ##1 input_channel_enable[0] == $past(reg_wdata[7], 2)
      && input_channel_enable[NUM_CH-1] == $past(reg_wdata[0], 2);
  endproperty
  a_deci: assert property (p_deci) else $error("decimation select wrong");
  a_sum0: assert property (p_sum0) else $error("unsummed count wrong");
  a_sum1: assert property (p_sum1) else $error("pair count wrong");
  a_sum2: assert property (p_sum2) else $error("quad count wrong");
  a_hpf: assert property (p_hpf) else $error("programmable highpass wrong");
  a_soft: assert property (p_soft) else $error("soft step wrong");
  a_ceil: assert property (p_ceil) else $error("ceiling wrong");
  a_inen: assert property (p_inen) else $error("input enable order wrong");
  c_rd: cover property (reg_rvalid);
  c_quad: cover property (channel_summing_mode == 2'h2);
  c_nosoft: cover property (!soft_step_enable);
endmodule
